// >>> core/ccmm_pkg.sv
package ccmm_pkg;
  localparam int WORD_W = 16;
  localparam int CTRL_BIT = 15;
  localparam int RDBK_BIT = 14;
  localparam int ADDR_LO = 11;
  localparam int SEL_LO = 8;
  localparam logic [2:0] ADDR_SELF = 3'h0;
  localparam logic [2:0] ADDR_WRAP = 3'h7;
  localparam logic [2:0] SEL_CRA = 3'h0;
  localparam logic [2:0] SEL_CRB = 3'h1;
  localparam logic [2:0] SEL_CRC = 3'h2;
  // Control register A fields
  localparam int CRA_PROGRAM_OR_DATA_SELECT = 0;
  localparam int CRA_MM = 1;
  localparam int CRA_DC_LO = 4;
  // Control register B fields
  localparam int CRB_SCDIV_LO = 0;
  localparam int CRB_RATE_LO = 2;
  localparam int CRB_MCDIV_LO = 4;
  // Control register C field
  localparam int CRC_PWR = 0;
  localparam logic [7:0] CR_RESET = 8'h00;
  // Serial clock half period in mclk cycles at the fastest setting
  localparam logic [15:0] SCLK_HALF_BASE = 16'h0008;
  // Sample period in serial clock periods at the fastest rate setting
  localparam logic [8:0] SAMPLE_BASE = 9'h020;
  localparam logic [4:0] BITS_PER_WORD = 5'h10;
  localparam logic [3:0] BITS_AFTER_MSB = 4'hf;
  // Host command port map
  localparam logic [1:0] HOST_TX = 2'h0;
  localparam logic [1:0] HOST_RX = 2'h1;
  localparam logic [1:0] HOST_STAT = 2'h2;
  localparam logic [1:0] HOST_CTRL = 2'h3;
  localparam int STAT_RX_VALID = 0;
  localparam int STAT_TX_FULL = 1;
  localparam int STAT_TX_BUSY = 2;
  localparam int STAT_RX_OVR = 3;
  localparam int CTRL_LOOPBACK = 0;
  typedef enum logic [2:0] {
    CCMM_TX_IDLE = 3'h1,
    CCMM_TX_SYNC = 3'h2,
    CCMM_TX_BITS = 3'h4
  } ccmm_tx_e;
endpackage : ccmm_pkg

// >>> core/ccmm_link_if.sv
`timescale 1ns/10ps
interface ccmm_link_if;
  logic serial_clock;
  logic serial_in_frame_sync;
  logic serial_in_data;
  logic serial_out_frame_sync;
  logic serial_data_output;
  modport dev_mp (
    output serial_clock,
    input serial_in_frame_sync,
    input serial_in_data,
    output serial_out_frame_sync,
    output serial_data_output
  );
  modport host_mp (
    input serial_clock,
    output serial_in_frame_sync,
    output serial_in_data,
    input serial_out_frame_sync,
    input serial_data_output
  );
endinterface : ccmm_link_if

// >>> core/ccmm_device.sv
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
module ccmm_device (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  ccmm_link_if.dev_mp lnk,
  input wire logic [15:0] adc_word,
  output logic [15:0] dac_word,
  output logic dac_update,
  output logic analog_on,
  output logic mixed_mode_bit,
  output logic program_or_data_select
);
  typedef struct packed {
    ccmm_pkg::ccmm_tx_e tx;
    logic [15:0] div_cnt;
    logic sclk;
    logic [8:0] per_cnt;
    logic sample_due;
    logic [15:0] tx_sh;
    logic [3:0] tx_left;
    logic out_fs;
    logic out_data;
    logic [1:0] in_fs_sync;
    logic [1:0] in_data_sync;
    logic rx_act;
    logic [15:0] rx_sh;
    logic [4:0] rx_left;
    logic [15:0] fwd_word;
    logic fwd_v;
    logic [2:0] fs_cnt;
    logic [7:0][7:0] regs;
    logic [15:0] dac;
    logic dac_stb;
  } ccmm_dev_s;

  ccmm_dev_s r;
  ccmm_dev_s n;
  logic rise;
  logic fall;
  logic prog;
  logic is_ctrl;
  logic [15:0] w;
  logic [2:0] addr;
  logic [2:0] sel;

  // Serial clock half period from the master and serial dividers
  function automatic logic [15:0] half_period(input logic [7:0] control_reg_second);
    logic [15:0] base;
    logic [1:0] shift;
    base = ccmm_pkg::SCLK_HALF_BASE * {13'h0000, control_reg_second[ccmm_pkg::CRB_MCDIV_LO +: 3]}
      + ccmm_pkg::SCLK_HALF_BASE;
    shift = 2'h3 - control_reg_second[ccmm_pkg::CRB_SCDIV_LO +: 2];
    return base << shift;
  endfunction : half_period

  // Sample period counted in serial clock periods
  function automatic logic [8:0] sample_period(input logic [7:0] control_reg_second);
    return ccmm_pkg::SAMPLE_BASE << control_reg_second[ccmm_pkg::CRB_RATE_LO +: 2];
  endfunction : sample_period

  always_comb begin
    n = r;
    rise = 1'b0;
    fall = 1'b0;
    w = {r.rx_sh[14:0], r.in_data_sync[1]};
    addr = w[ccmm_pkg::ADDR_LO +: 3];
    sel = w[ccmm_pkg::SEL_LO +: 3];
    is_ctrl = w[ccmm_pkg::CTRL_BIT];
    prog = ~r.regs[ccmm_pkg::SEL_CRA][ccmm_pkg::CRA_PROGRAM_OR_DATA_SELECT];
    n.in_fs_sync = {r.in_fs_sync[0], lnk.serial_in_frame_sync};
    n.in_data_sync = {r.in_data_sync[0], lnk.serial_in_data};
    n.dac_stb = 1'b0;
    // Every device leaves reset with identical counters, so a cascade stays in step
    if (r.div_cnt == half_period(r.regs[ccmm_pkg::SEL_CRB]) - 16'h0001) begin
      n.div_cnt = 16'h0000;
      n.sclk = ~r.sclk;
      rise = ~r.sclk;
      fall = r.sclk;
    end else begin
      n.div_cnt = r.div_cnt + 16'h0001;
    end

    if (fall) begin
      if (r.per_cnt >= sample_period(r.regs[ccmm_pkg::SEL_CRB]) - 9'h001) begin
        n.per_cnt = 9'h000;
        n.sample_due = 1'b1;
      end else begin
        n.per_cnt = r.per_cnt + 9'h001;
      end
      n.out_fs = 1'b0;
      unique case (r.tx)
        ccmm_pkg::CCMM_TX_IDLE: begin
        end
        ccmm_pkg::CCMM_TX_SYNC: begin
          n.out_data = r.tx_sh[15];
          n.tx_sh = {r.tx_sh[14:0], 1'b0};
          n.tx_left = ccmm_pkg::BITS_AFTER_MSB;
          n.tx = ccmm_pkg::CCMM_TX_BITS;
        end
        ccmm_pkg::CCMM_TX_BITS: begin
          if (r.tx_left != 4'h0) begin
            n.out_data = r.tx_sh[15];
            n.tx_sh = {r.tx_sh[14:0], 1'b0};
            n.tx_left = r.tx_left - 4'h1;
          end else begin
            n.tx = ccmm_pkg::CCMM_TX_IDLE;
            n.out_data = 1'b0;
          end
        end
      endcase
      // A new frame may start on the fall that ends the previous one: no gap
      if (n.tx == ccmm_pkg::CCMM_TX_IDLE) begin
        if (n.sample_due) begin
          n.sample_due = 1'b0;
          // Converter is unpowered until register C enables it
          n.tx_sh = r.regs[ccmm_pkg::SEL_CRC][ccmm_pkg::CRC_PWR] ? adc_word : 16'h0000;
          n.out_fs = 1'b1;
          n.out_data = 1'b0;
          n.tx = ccmm_pkg::CCMM_TX_SYNC;
        end else if (r.fwd_v) begin
          n.fwd_v = 1'b0;
          n.tx_sh = r.fwd_word;
          n.out_fs = 1'b1;
          n.out_data = 1'b0;
          n.tx = ccmm_pkg::CCMM_TX_SYNC;
        end
      end
    end

    if (rise) begin
      if (r.rx_act) begin
        n.rx_sh = w;
        n.rx_left = r.rx_left - 5'h01;
        if (r.rx_left == 5'h01) begin
          n.rx_act = 1'b0;
          if (is_ctrl) begin
            if (addr == ccmm_pkg::ADDR_SELF) begin
              if (w[ccmm_pkg::RDBK_BIT]) begin
                // Readback leaves already one hop down, so address starts wrapped
                n.fwd_word = {w[15:14], ccmm_pkg::ADDR_WRAP, sel, r.regs[sel]};
                n.fwd_v = 1'b1;
              end else begin
                n.regs[sel] = w[7:0];
              end
            end else begin
              n.fwd_word = {w[15:14], addr - 3'h1, w[10:0]};
              n.fwd_v = 1'b1;
            end
          end else if (!prog) begin
            // Upstream sample words count too: they ride the same frame syncs
            if (r.fs_cnt == r.regs[ccmm_pkg::SEL_CRA][ccmm_pkg::CRA_DC_LO +: 3]) begin
              n.dac = w;
              n.dac_stb = 1'b1;
              n.fs_cnt = 3'h0;
            end else begin
              n.fs_cnt = r.fs_cnt + 3'h1;
              n.fwd_word = w;
              n.fwd_v = 1'b1;
            end
          end else begin
            n.fwd_word = w;
            n.fwd_v = 1'b1;
          end
        end
      end else if (r.in_fs_sync[1]) begin
        n.rx_act = 1'b1;
        n.rx_left = ccmm_pkg::BITS_PER_WORD;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      r <= '0;
      r.tx <= ccmm_pkg::CCMM_TX_IDLE;
    end else if (ce) begin
      r <= n;
    end
  end

  assign lnk.serial_clock = r.sclk;
  assign lnk.serial_out_frame_sync = r.out_fs;
  assign lnk.serial_data_output = r.out_data;
  assign dac_word = r.dac;
  assign dac_update = r.dac_stb;
  assign analog_on = r.regs[ccmm_pkg::SEL_CRC][ccmm_pkg::CRC_PWR];
  assign mixed_mode_bit = r.regs[ccmm_pkg::SEL_CRA][ccmm_pkg::CRA_MM];
  assign program_or_data_select = r.regs[ccmm_pkg::SEL_CRA][ccmm_pkg::CRA_PROGRAM_OR_DATA_SELECT];
endmodule : ccmm_device

// >>> core/ccmm_host.sv
`timescale 1ns/10ps
module ccmm_host (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  ccmm_link_if.host_mp lnk,
  input wire logic [1:0] host_addr,
  input wire logic [15:0] host_wdata,
  input wire logic host_wr,
  input wire logic host_rd,
  output logic [15:0] host_rdata
);
  typedef struct packed {
    logic [1:0] sclk_sync;
    logic sclk_d;
    logic [1:0] fs_sync;
    logic [1:0] data_sync;
    ccmm_pkg::ccmm_tx_e tx;
    logic [15:0] tx_sh;
    logic [3:0] tx_left;
    logic out_fs;
    logic out_data;
    logic [15:0] nxt;
    logic nxt_v;
    logic fs_seen;
    logic loopback;
    logic rx_act;
    logic [15:0] rx_sh;
    logic [4:0] rx_left;
    logic [15:0] rx_word;
    logic rx_v;
    logic rx_ovr;
    logic [15:0] rdata;
  } ccmm_host_s;

  ccmm_host_s r;
  ccmm_host_s n;
  logic rise;
  logic fall;
  logic [15:0] w;

  always_comb begin
    n = r;
    n.sclk_sync = {r.sclk_sync[0], lnk.serial_clock};
    n.fs_sync = {r.fs_sync[0], lnk.serial_out_frame_sync};
    n.data_sync = {r.data_sync[0], lnk.serial_data_output};
    n.sclk_d = r.sclk_sync[1];
    rise = r.sclk_sync[1] & ~r.sclk_d;
    fall = ~r.sclk_sync[1] & r.sclk_d;
    w = {r.rx_sh[14:0], r.data_sync[1]};
    n.rdata = 16'h0000;

    if (host_rd) begin
      unique case (host_addr)
        ccmm_pkg::HOST_TX: n.rdata = r.nxt;
        ccmm_pkg::HOST_RX: begin
          n.rdata = r.rx_word;
          n.rx_v = 1'b0;
        end
        ccmm_pkg::HOST_STAT: begin
          n.rdata[ccmm_pkg::STAT_RX_VALID] = r.rx_v;
          n.rdata[ccmm_pkg::STAT_TX_FULL] = r.nxt_v;
          n.rdata[ccmm_pkg::STAT_TX_BUSY] = r.tx != ccmm_pkg::CCMM_TX_IDLE;
          n.rdata[ccmm_pkg::STAT_RX_OVR] = r.rx_ovr;
        end
        ccmm_pkg::HOST_CTRL: n.rdata[ccmm_pkg::CTRL_LOOPBACK] = r.loopback;
      endcase
    end
    if (host_wr) begin
      unique case (host_addr)
        // A full slot refuses the write; software polls the status first
        ccmm_pkg::HOST_TX: begin
          if (!r.nxt_v) begin
            n.nxt = host_wdata;
            n.nxt_v = 1'b1;
          end
        end
        ccmm_pkg::HOST_STAT: begin
          if (host_wdata[ccmm_pkg::STAT_RX_OVR]) begin
            n.rx_ovr = 1'b0;
          end
        end
        ccmm_pkg::HOST_CTRL: n.loopback = host_wdata[ccmm_pkg::CTRL_LOOPBACK];
        default: begin
        end
      endcase
    end

    if (fall) begin
      n.out_fs = 1'b0;
      unique case (r.tx)
        ccmm_pkg::CCMM_TX_IDLE: begin
        end
        ccmm_pkg::CCMM_TX_SYNC: begin
          n.out_data = r.tx_sh[15];
          n.tx_sh = {r.tx_sh[14:0], 1'b0};
          n.tx_left = ccmm_pkg::BITS_AFTER_MSB;
          n.tx = ccmm_pkg::CCMM_TX_BITS;
        end
        ccmm_pkg::CCMM_TX_BITS: begin
          if (r.tx_left != 4'h0) begin
            n.out_data = r.tx_sh[15];
            n.tx_sh = {r.tx_sh[14:0], 1'b0};
            n.tx_left = r.tx_left - 4'h1;
          end else begin
            n.tx = ccmm_pkg::CCMM_TX_IDLE;
            n.out_data = 1'b0;
          end
        end
      endcase
      // Start on the same fall as the previous word ends, keeping words gapless
      if (n.tx == ccmm_pkg::CCMM_TX_IDLE && r.nxt_v && (!r.loopback || r.fs_seen)) begin
        n.nxt_v = 1'b0;
        n.fs_seen = 1'b0;
        n.tx_sh = r.nxt;
        n.out_fs = 1'b1;
        n.out_data = 1'b0;
        n.tx = ccmm_pkg::CCMM_TX_SYNC;
      end
    end

    if (rise) begin
      if (r.rx_act) begin
        n.rx_sh = w;
        n.rx_left = r.rx_left - 5'h01;
        if (r.rx_left == 5'h01) begin
          n.rx_act = 1'b0;
          n.rx_word = w;
          // Set wins over the read that clears it in the same cycle
          if (r.rx_v && !(host_rd && host_addr == ccmm_pkg::HOST_RX)) begin
            n.rx_ovr = 1'b1;
          end
          n.rx_v = 1'b1;
        end
      end else if (r.fs_sync[1]) begin
        n.rx_act = 1'b1;
        n.rx_left = ccmm_pkg::BITS_PER_WORD;
        n.fs_seen = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      r <= '0;
      r.tx <= ccmm_pkg::CCMM_TX_IDLE;
    end else if (ce) begin
      r <= n;
    end
  end

  assign lnk.serial_in_frame_sync = r.out_fs;
  assign lnk.serial_in_data = r.out_data;
  assign host_rdata = r.rdata;
endmodule : ccmm_host

// >>> tb/ccmm_monitor.sv
`timescale 1ns/10ps
module ccmm_monitor (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic serial_clock,
  input wire logic serial_in_frame_sync,
  input wire logic serial_in_data,
  input wire logic serial_out_frame_sync,
  input wire logic serial_data_output
);
  typedef struct packed {
    logic [4:0] out_bits;
    logic [4:0] in_bits;
    logic [6:0] half_cnt;
    logic sclk_d;
  } ccmm_mon_s;
  ccmm_mon_s st;
  ccmm_mon_s next_st;
  logic sclk_rise;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  assign sclk_rise = serial_clock && !st.sclk_d;
  // Bit counters start at 16, one whole word, so the first frame after reset is legal
  always_comb begin
    next_st = st;
    next_st.sclk_d = serial_clock;
    if (serial_clock != st.sclk_d) begin
      next_st.half_cnt = 7'h00;
    end else if (st.half_cnt != 7'h7f) begin
      next_st.half_cnt = st.half_cnt + 7'h01;
    end
    if (sclk_rise) begin
      next_st.out_bits = serial_out_frame_sync ? 5'h00 :
        ((st.out_bits == 5'h1f) ? st.out_bits : st.out_bits + 5'h01);
      next_st.in_bits = serial_in_frame_sync ? 5'h00 :
        ((st.in_bits == 5'h1f) ? st.in_bits : st.in_bits + 5'h01);
    end
    if (!reset_n) begin
      next_st = '{out_bits: 5'h10, in_bits: 5'h10, default: '0};
    end
  end
  always_ff @(posedge mclk) begin
    st <= next_st;
  end
  a_reset_quiet: assert property ($rose(reset_n) |->
    !serial_clock && !serial_out_frame_sync && !serial_data_output)
    else $error("link outputs not idle after reset");
  a_out_change_low: assert property ($changed(serial_data_output) |-> !serial_clock)
    else $error("device data changed while serial clock high");
  a_in_change_low: assert property ($changed(serial_in_data) |-> !serial_clock)
    else $error("host data changed while serial clock high");
  a_sclk_half_min: assert property ($changed(serial_clock) |=> $stable(serial_clock)[*7])
    else $error("serial clock half period below eight cycles");
  a_sclk_half_max: assert property (st.half_cnt <= 7'h42)
    else $error("serial clock half period too long");
  a_out_fs_width: assert property ($rose(serial_out_frame_sync) |=>
    serial_out_frame_sync[*8] ##[1:122] !serial_out_frame_sync)
    else $error("device frame sync not one serial period");
  a_in_fs_width: assert property ($rose(serial_in_frame_sync) |=>
    serial_in_frame_sync[*8] ##[1:122] !serial_in_frame_sync)
    else $error("host frame sync not one serial period");
  a_out_word_gap: assert property (sclk_rise && serial_out_frame_sync |->
    st.out_bits >= 5'h10)
    else $error("device frame sync inside a word");
  a_in_word_gap: assert property (sclk_rise && serial_in_frame_sync |->
    st.in_bits >= 5'h10)
    else $error("host frame sync inside a word");
  a_out_idle_low: assert property (serial_data_output |-> st.out_bits <= 5'h10)
    else $error("device data high outside a word");
  a_in_idle_low: assert property (serial_in_data |-> st.in_bits <= 5'h10)
    else $error("host data high outside a word");
  c_dev_frame: cover property ($rose(serial_out_frame_sync));
  c_host_frame: cover property ($rose(serial_in_frame_sync));
  c_fast_clock: cover property ($changed(serial_clock) ##8 $changed(serial_clock));
endmodule : ccmm_monitor

// >>> tb/codec_cascade_mixed_mode_port_tb.sv
`timescale 1ns/10ps
module codec_cascade_mixed_mode_port_tb;
  typedef struct packed {
    logic [15:0] tx;
    logic [15:0] rx;
    logic has_rx;
  } ccmm_row_s;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic ce = 1'b1;
  logic [1:0] host_addr = 2'h0;
  logic [15:0] host_wdata = 16'h0000;
  logic host_wr = 1'b0;
  logic host_rd = 1'b0;
  logic [15:0] adc_word = 16'h1234;
  logic [15:0] host_rdata;
  logic [15:0] dac_word;
  logic dac_update;
  logic analog_on;
  logic mixed_mode_bit;
  logic program_or_data_select;
  int n_mismatch = 0;
  int n_checks = 0;
  int n_upd = 0;
  ccmm_row_s rows [11];
  logic [15:0] w;
  ccmm_link_if lnk ();
  ccmm_device ccmm_device_i (.mclk(mclk), .reset_n(reset_n), .ce(ce), .lnk(lnk),
    .adc_word(adc_word), .dac_word(dac_word), .dac_update(dac_update),
    .analog_on(analog_on), .mixed_mode_bit(mixed_mode_bit),
    .program_or_data_select(program_or_data_select));
  ccmm_host ccmm_host_i (.mclk(mclk), .reset_n(reset_n), .ce(ce), .lnk(lnk),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd),
    .host_rdata(host_rdata));
  ccmm_monitor ccmm_monitor_i (.mclk(mclk), .reset_n(reset_n),
    .serial_clock(lnk.serial_clock), .serial_in_frame_sync(lnk.serial_in_frame_sync),
    .serial_in_data(lnk.serial_in_data), .serial_out_frame_sync(lnk.serial_out_frame_sync),
    .serial_data_output(lnk.serial_data_output));
  always #4 mclk = ~mclk;
  always @(posedge mclk) begin
    if (dac_update === 1'b1) n_upd++;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic timeout(input string nm);
    n_mismatch++;
    $display("FAIL %s expected done seen timeout", nm);
    end_of_test();
  endtask : timeout
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge mclk);
    host_addr <= a;
    host_wdata <= d;
    host_wr <= 1'b1;
    @(posedge mclk);
    host_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, output logic [15:0] d);
    @(posedge mclk);
    host_addr <= a;
    host_rd <= 1'b1;
    @(posedge mclk);
    host_rd <= 1'b0;
    #1 d = host_rdata;
  endtask : rd
  task automatic get_rx(output logic [15:0] d);
    logic [15:0] s;
    int i;
    for (i = 0; i < 6000; i++) begin
      rd(ccmm_pkg::HOST_STAT, s);
      if (s[ccmm_pkg::STAT_RX_VALID] === 1'b1) break;
    end
    if (i == 6000) timeout("rx word");
    rd(ccmm_pkg::HOST_RX, d);
  endtask : get_rx
  task automatic tx(input logic [15:0] d);
    logic [15:0] s;
    int i;
    for (i = 0; i < 3000; i++) begin
      rd(ccmm_pkg::HOST_STAT, s);
      if (s[ccmm_pkg::STAT_TX_FULL] === 1'b0) break;
    end
    if (i == 3000) timeout("tx slot");
    wr(ccmm_pkg::HOST_TX, d);
  endtask : tx
  // Sample frames interleave freely, so zero and live ADC words are skipped
  task automatic expect_rx(input logic [15:0] exp);
    for (int k = 0; k < 6; k++) begin
      get_rx(w);
      if (w !== 16'h0000 && w !== adc_word) break;
    end
    check("rx word", exp, w);
  endtask : expect_rx
  task automatic reset_chk();
    check("dac word", 16'h0000, dac_word);
    check("flags", 16'h0000, {12'h000, dac_update, analog_on, mixed_mode_bit,
      program_or_data_select});
    check("rdata", 16'h0000, host_rdata);
  endtask : reset_chk
  initial begin
    int i;
    rows = '{
      '{16'h810b, 16'h0000, 1'b0},
      '{16'hc100, 16'hf90b, 1'b1},
      '{16'h8013, 16'h0000, 1'b0},
      '{16'h8201, 16'h0000, 1'b0},
      '{16'h8355, 16'h0000, 1'b0},
      '{16'hc300, 16'hfb55, 1'b1},
      '{16'h0abc, 16'h0abc, 1'b1},
      '{16'h9255, 16'h8a55, 1'b1},
      '{16'h1357, 16'h0000, 1'b0},
      '{16'h2468, 16'h2468, 1'b1},
      '{16'h0246, 16'h0000, 1'b0}
    };
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    #1 reset_chk();
    get_rx(w);
    check("first sample", 16'h0000, w);
    for (int r = 0; r < 11; r++) begin
      tx(rows[r].tx);
      if (rows[r].has_rx) expect_rx(rows[r].rx);
    end
    for (i = 0; i < 4000 && n_upd < 2; i++) @(posedge mclk);
    if (n_upd < 2) timeout("dac update");
    repeat (2) @(posedge mclk);
    check("dac word", 16'h0246, dac_word);
    check("dac updates", 16'h0002, 16'(n_upd));
    check("flags", 16'h0007, {12'h000, dac_update, analog_on, mixed_mode_bit,
      program_or_data_select});
    get_rx(w);
    check("adc word", adc_word, w);
    // Loopback holds each host word until a device frame has been seen
    wr(ccmm_pkg::HOST_CTRL, 16'h0001);
    rd(ccmm_pkg::HOST_CTRL, w);
    check("loopback", 16'h0001, w);
    tx(16'h8466);
    tx(16'hc400);
    expect_rx(16'hfc66);
    // Clock enable low must freeze the serial clock and any device frame in flight
    @(posedge mclk);
    ce <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 w = {13'h0000, lnk.serial_clock, lnk.serial_out_frame_sync, lnk.serial_data_output};
    repeat (20) @(posedge mclk);
    #1 check("frozen link", w, {13'h0000, lnk.serial_clock, lnk.serial_out_frame_sync,
      lnk.serial_data_output});
    @(posedge mclk);
    ce <= 1'b1;
    // Mid-run reset must drop the device back to program mode, analog off
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    #1 reset_chk();
    get_rx(w);
    check("sample after reset", 16'h0000, w);
    end_of_test();
  end
endmodule : codec_cascade_mixed_mode_port_tb
